// ==== design/aptc_map.vh ====
// register map, field positions, reset values and trigger codes
// of the converter pair trigger control block
// assumes a 32-bit classic Wishbone slave with word-aligned registers
`ifndef APTC_MAP_VH
`define APTC_MAP_VH

// ----------------------------------------------------------------
// register word index (byte address = index * 4)
// ----------------------------------------------------------------
`define APTC_IDX_PIN_CFG   2'h0
`define APTC_IDX_PAIR_01   2'h1
`define APTC_IDX_PAIR_23   2'h2
`define APTC_IDX_LSB       2
`define APTC_IDX_MSB       3

// ----------------------------------------------------------------
// pin configuration register
// ----------------------------------------------------------------
`define APTC_PIN_W         12
`define APTC_RST_PIN_CFG   12'h000
`define APTC_PIN_PAD       20'h00000

// ----------------------------------------------------------------
// one pair byte; odd pair sits at bit offset 8
// ----------------------------------------------------------------
`define APTC_F_IRQ_EN      7
`define APTC_F_PAIR_PENDING_FLAG        6
`define APTC_F_SOFT_TRIG   5
`define APTC_F_SRC_MSB     4
`define APTC_F_SRC_LSB     0
`define APTC_SRC_W         5
`define APTC_ODD_SHIFT     8
`define APTC_RST_SRC       5'h00
`define APTC_CTL_PAD       16'h0000

// ----------------------------------------------------------------
// trigger source codes
// ----------------------------------------------------------------
`define APTC_SRC_NONE      5'h00
`define APTC_SRC_SOFT      5'h01
`define APTC_SRC_GLOBAL    5'h02
`define APTC_SRC_SPECIAL   5'h03
`define APTC_SRC_GEN1      5'h04
`define APTC_SRC_TMR1      5'h0C
`define APTC_SRC_ILIM1     5'h0E
`define APTC_SRC_FAULT1    5'h16
`define APTC_SRC_GEN2      5'h05
`define APTC_SRC_GEN3      5'h06
`define APTC_SRC_GEN4      5'h07
`define APTC_SRC_TMR2      5'h0D
`define APTC_SRC_ILIM2     5'h0F
`define APTC_SRC_ILIM3     5'h10
`define APTC_SRC_ILIM4     5'h11
`define APTC_SRC_FAULT2    5'h17
`define APTC_SRC_FAULT3    5'h18
`define APTC_SRC_FAULT4    5'h19

`endif

// ==== design/aptc_ctrl.v ====
// trigger and request logic for a paired-input converter
// assumes a classic Wishbone master, trigger inputs synchronous to
// clk_i, and a converter core that pulses conv_done_i once per start
// each high cycle of a selected trigger sets the pending flag; a held level re-arms
// pending bits are owned by hardware, writes to them are dropped
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "aptc_map.vh"

// Functional notes
// - select bit 1: digital read path on, converter mux tied to ground
// - select bit 0: digital read path off, converter samples the pin
// - pin configuration bits 15 to 12 always read as zero
// - enabled pair raises an interrupt request when its conversion completes
// - selected trigger asserted sets the pair pending flag
// - pending flag clears when the pair conversion completes
// - soft trigger write requests conversion only if soft source selected
// - triggers for other pairs during a busy conversion are held and served later
// - soft trigger bit clears when the pending flag sets
// - odd pair field at bits 12 to 8, even pair at 4 to 0
// - source code zero never sets the pending flag
// - code 1 own soft trigger, code 2 global soft trigger
// - code 3 selects the special event trigger
// - codes 4 to 7 select generator 1 to 4 triggers
// - codes 12 and 13 select timer 1 and 2 period match
// - codes 14 to 17 select generator current-limit triggers
// - codes 22 to 25 select generator fault triggers
// - pair n converts inputs 2n+1 and 2n
module aptc_ctrl #(
  parameter ADR_W = 8
) (
  // clock and reset
  input  wire              clk_i,
  input  wire              rst_i,
  // wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [ADR_W-1:0]  wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output wire [31:0]       wb_dat_o,
  output wire              wb_ack_o,
  // pin mode controls
  output wire [11:0]       pin_dig_read_en_o,
  output wire [11:0]       pin_mux_gnd_o,
  output wire [11:0]       pin_sample_en_o,
  // trigger sources
  input  wire              glob_soft_trig_i,
  input  wire              pwm_spec_evt_i,
  input  wire [3:0]        pwm_gen_trig_i,
  input  wire [1:0]        tmr_period_i,
  input  wire [3:0]        pwm_ilim_trig_i,
  input  wire [3:0]        pwm_fault_trig_i,
  // converter core
  output wire              conv_start_o,
  output wire [1:0]        conv_pair_o,
  output wire [3:0]        conv_an_even_o,
  input  wire              conv_done_i,
  // per pair interrupt requests
  output wire [3:0]        pair_irq_o
);

  localparam NPAIR = 4;
  localparam [1:0] CS_IDLE = 2'h0;
  localparam [1:0] CS_BUSY = 2'h1;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg                      ack_q;
  reg  [31:0]              dat_q;
  reg  [31:0]              rdata_d;
  reg  [`APTC_PIN_W-1:0]   cfg_q;
  reg  [`APTC_PIN_W-1:0]   smp_q;
  reg  [NPAIR-1:0]         irq_en_q;
  reg  [NPAIR-1:0]         soft_q;
  reg  [NPAIR-1:0]         pair_pending_flag_q;
  reg  [NPAIR-1:0]         started_q;
  reg  [NPAIR*5-1:0]       src_q;
  reg  [NPAIR-1:0]         irq_q;
  reg                      busy_q;
  reg  [1:0]               act_q;
  reg                      start_q;
  reg  [1:0]               pair_q;
  reg  [3:0]               an_even_q;
  reg  [1:0]               gsel_d;
  reg                      gnt_d;
  reg  [1:0]               cs_q;
  reg  [1:0]               cs_d;
  integer                  i;

  wire [NPAIR-1:0]         hit_w;
  wire [NPAIR-1:0]         done_w;
  wire [NPAIR*8-1:0]       pbyte_w;
  wire [NPAIR-1:0]         wait_w;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire       req_w  = wb_cyc_i & wb_stb_i & ~ack_q;
  wire [1:0] idx_w  = wb_adr_i[`APTC_IDX_MSB:`APTC_IDX_LSB];
  // only the low address bits select; any higher bit makes the word unmapped
  wire       hi0_w  = (wb_adr_i[ADR_W-1:4] == {(ADR_W-4){1'b0}});
  wire       wr_w   = req_w & wb_we_i & hi0_w;
  wire       wr_pin = wr_w & (idx_w == `APTC_IDX_PIN_CFG);
  wire       wr_p01 = wr_w & (idx_w == `APTC_IDX_PAIR_01);
  wire       wr_p23 = wr_w & (idx_w == `APTC_IDX_PAIR_23);

  // read words; bits above each register read as zero
  wire [31:0] rd_pin_w = {`APTC_PIN_PAD, cfg_q};
  wire [31:0] rd_p01_w = {`APTC_CTL_PAD, pbyte_w[15:0]};
  wire [31:0] rd_p23_w = {`APTC_CTL_PAD, pbyte_w[31:16]};

  // unmapped words still ack, reading zero
  always @* begin
    rdata_d = 32'h00000000;
    if (hi0_w) begin
      case (idx_w)
        `APTC_IDX_PIN_CFG: rdata_d = rd_pin_w;
        `APTC_IDX_PAIR_01: rdata_d = rd_p01_w;
        `APTC_IDX_PAIR_23: rdata_d = rd_p23_w;
        default:           rdata_d = 32'h00000000;
      endcase
    end
  end

  // one-cycle answer; ~ack_q in req_w keeps a held request from repeating
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_w;
    end
  end

  // read data stays until the next read
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h00000000;
    end else if (req_w & ~wb_we_i) begin
      dat_q <= rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------------------------------
  // pin configuration
  // ----------------------------------------------------------------
  localparam [`APTC_PIN_W-1:0] PIN_RST = `APTC_RST_PIN_CFG;

  // one mode bit per pin; lane 0 holds pins 7 to 0, lane 1 pins 11 to 8
  genvar n;
  generate
    for (n = 0; n < `APTC_PIN_W; n = n + 1) begin : g_pin
      wire lane_wr = wr_pin & wb_sel_i[n / 8];
      always @(posedge clk_i) begin
        if (rst_i) begin
          cfg_q[n] <= PIN_RST[n];
          smp_q[n] <= ~PIN_RST[n];
        end else if (lane_wr) begin
          cfg_q[n] <= wb_dat_i[n];
          smp_q[n] <= ~wb_dat_i[n];
        end
      end
    end
  endgenerate

  assign pin_dig_read_en_o = cfg_q;
  assign pin_mux_gnd_o     = cfg_q;
  assign pin_sample_en_o   = smp_q;

  // ----------------------------------------------------------------
  // per pair control
  // ----------------------------------------------------------------
  // a trigger for a pair that is already pending is absorbed; only a
  // trigger in the very cycle of completion re-arms the pair, because
  // the set of the pending flag wins over the clear
  // a user that needs every event counted must pace its triggers
  genvar p;
  generate
    for (p = 0; p < NPAIR; p = p + 1) begin : g_pair
      // two pairs per register, odd pair in the upper byte
      wire       wr_me = ((p < 2) ? wr_p01 : wr_p23) & wb_sel_i[p % 2];
      wire [7:0] wbyte = wb_dat_i[(p % 2)*`APTC_ODD_SHIFT +: 8];
      wire [4:0] src   = src_q[5*p +: 5];
      wire [4:0] nsrc  = wbyte[`APTC_F_SRC_MSB:`APTC_F_SRC_LSB];
      // the same write must select the own soft trigger
      wire       soft_ok = (nsrc == `APTC_SRC_SOFT);
      reg        tsel;

      // code zero and unlisted codes select nothing
      always @* begin
        tsel = 1'b0;
        case (src)
          `APTC_SRC_NONE:    tsel = 1'b0;
          `APTC_SRC_SOFT:    tsel = soft_q[p];
          `APTC_SRC_GLOBAL:  tsel = glob_soft_trig_i;
          `APTC_SRC_SPECIAL: tsel = pwm_spec_evt_i;
          // generator triggers 1 to 4
          `APTC_SRC_GEN1:    tsel = pwm_gen_trig_i[0];
          `APTC_SRC_GEN2:    tsel = pwm_gen_trig_i[1];
          `APTC_SRC_GEN3:    tsel = pwm_gen_trig_i[2];
          `APTC_SRC_GEN4:    tsel = pwm_gen_trig_i[3];
          `APTC_SRC_TMR1:    tsel = tmr_period_i[0];
          `APTC_SRC_TMR2:    tsel = tmr_period_i[1];
          // current-limit triggers 1 to 4
          `APTC_SRC_ILIM1:   tsel = pwm_ilim_trig_i[0];
          `APTC_SRC_ILIM2:   tsel = pwm_ilim_trig_i[1];
          `APTC_SRC_ILIM3:   tsel = pwm_ilim_trig_i[2];
          `APTC_SRC_ILIM4:   tsel = pwm_ilim_trig_i[3];
          // fault triggers 1 to 4
          `APTC_SRC_FAULT1:  tsel = pwm_fault_trig_i[0];
          `APTC_SRC_FAULT2:  tsel = pwm_fault_trig_i[1];
          `APTC_SRC_FAULT3:  tsel = pwm_fault_trig_i[2];
          `APTC_SRC_FAULT4:  tsel = pwm_fault_trig_i[3];
          default:           tsel = 1'b0;
        endcase
      end

      assign hit_w[p]  = tsel;
      // completion of this pair's conversion; a stray done is ignored
      assign done_w[p] = conv_done_i & busy_q & (act_q == p);
      // waiting means pending and not yet handed to the converter
      assign wait_w[p] = pair_pending_flag_q[p] & ~started_q[p];
      // read byte of this pair
      assign pbyte_w[8*p +: 8] = {irq_en_q[p], pair_pending_flag_q[p], soft_q[p], src};

      // fields written through this pair's byte lane
      always @(posedge clk_i) begin
        if (rst_i) begin
          irq_en_q[p]     <= 1'b0;
          src_q[5*p +: 5] <= `APTC_RST_SRC;
        end else if (wr_me) begin
          irq_en_q[p]     <= wbyte[`APTC_F_IRQ_EN];
          src_q[5*p +: 5] <= nsrc;
        end
      end

      // software trigger bit
      always @(posedge clk_i) begin
        if (rst_i) begin
          soft_q[p] <= 1'b0;
        // soft request kept only with soft source selected
        end else if (wr_me) begin
          soft_q[p] <= wbyte[`APTC_F_SOFT_TRIG] & soft_ok;
        // soft bit drops as pending sets
        end else if (hit_w[p]) begin
          soft_q[p] <= 1'b0;
        end
      end

      // pending flag; a trigger in the completion cycle wins
      always @(posedge clk_i) begin
        if (rst_i) begin
          pair_pending_flag_q[p] <= 1'b0;
        end else if (hit_w[p]) begin
          pair_pending_flag_q[p] <= 1'b1;
        end else if (done_w[p]) begin
          pair_pending_flag_q[p] <= 1'b0;
        end
      end

      // held until started by the arbiter
      always @(posedge clk_i) begin
        if (rst_i) begin
          started_q[p] <= 1'b0;
        end else if (gnt_d & (gsel_d == p)) begin
          started_q[p] <= 1'b1;
        end else if (done_w[p]) begin
          started_q[p] <= 1'b0;
        end
      end

      // one request pulse per completion when enabled
      always @(posedge clk_i) begin
        if (rst_i) begin
          irq_q[p] <= 1'b0;
        end else begin
          irq_q[p] <= done_w[p] & irq_en_q[p];
        end
      end
    end
  endgenerate

  assign pair_irq_o = irq_q;

  // ----------------------------------------------------------------
  // arbiter and converter handshake
  // ----------------------------------------------------------------
  // lowest waiting pair first
  always @* begin
    gsel_d = 2'h0;
    // scanning downwards leaves the lowest waiting index last
    for (i = NPAIR - 1; i >= 0; i = i - 1) begin
      if (wait_w[i]) begin
        gsel_d = i[1:0];
      end
    end
  end

  // start only when the converter is free
  // a granted pair leaves the waiting set at once, so grants never repeat
  always @* begin
    gnt_d = ~busy_q & (|wait_w);
  end

  // ----------------------------------------------------------------
  // converter state
  // ----------------------------------------------------------------
  always @* begin
    cs_d = cs_q;
    case (cs_q)
      CS_IDLE: begin
        if (gnt_d) begin
          cs_d = CS_BUSY;
        end
      end
      CS_BUSY: begin
        if (conv_done_i) begin
          cs_d = CS_IDLE;
        end
      end
      default: begin
        cs_d = CS_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cs_q      <= CS_IDLE;
      busy_q    <= 1'b0;
      act_q     <= 2'h0;
      start_q   <= 1'b0;
      pair_q    <= 2'h0;
      an_even_q <= 4'h0;
    end else begin
      cs_q    <= cs_d;
      busy_q  <= (cs_d == CS_BUSY);
      start_q <= gnt_d;
      if (gnt_d) begin
        act_q     <= gsel_d;
        pair_q    <= gsel_d;
        // pair n uses inputs 2n and 2n+1
        an_even_q <= {1'b0, gsel_d, 1'b0};
      end
    end
  end

  assign conv_start_o   = start_q;
  assign conv_pair_o    = pair_q;
  assign conv_an_even_o = an_even_q;

endmodule

// ==== tb/aptc_core_model.sv ====
// converter core model for the pair trigger bench
// assumes one start at a time; done comes lat_i+1 cycles later
`timescale 1ns/1ps
module aptc_core_model (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // start and latency
  input  wire       start_i,
  input  wire [3:0] lat_i,
  // completion
  output wire       done_o
);
  reg       busy_q;
  reg [3:0] cnt_q;
  // one done per start, never in the start cycle
  assign done_o = busy_q && cnt_q == 4'h0;
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
    end else if (start_i) begin
      busy_q <= 1'b1;
      cnt_q  <= lat_i;
    end else if (busy_q) begin
      busy_q <= cnt_q != 4'h0;
      cnt_q  <= cnt_q - 4'h1;
    end
  end
endmodule

// ==== tb/aptc_ctrl_monitor.sv ====
// port checker for the pair trigger control block
// assumes it is bound into aptc_ctrl
`timescale 1ns/1ps
module aptc_ctrl_monitor #(
  parameter ADR_W = 8
) (
  // clock and reset
  input wire             clk_i,
  input wire             rst_i,
  // bus
  input wire             wb_cyc_i,
  input wire             wb_stb_i,
  input wire             wb_we_i,
  input wire [ADR_W-1:0] wb_adr_i,
  input wire [31:0]      wb_dat_o,
  input wire             wb_ack_o,
  // pins and core
  input wire [11:0]      pin_dig_read_en_o,
  input wire [11:0]      pin_mux_gnd_o,
  input wire [11:0]      pin_sample_en_o,
  input wire             conv_start_o,
  input wire [1:0]       conv_pair_o,
  input wire [3:0]       conv_an_even_o,
  input wire             conv_done_i,
  input wire [3:0]       pair_irq_o
);
  reg busy_q;
  always @(posedge clk_i) begin
    if (rst_i) busy_q <= 1'b0;
    else if (conv_start_o) busy_q <= 1'b1;
    else if (conv_done_i) busy_q <= 1'b0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_dig_gnd: assert property (pin_mux_gnd_o == pin_dig_read_en_o)
    else $error("mux ground differs from read enable");
  chk_sample_inv: assert property (pin_sample_en_o == ~pin_dig_read_en_o)
    else $error("sample enable not inverse of mode");
  chk_reset_state: assert property ($fell(rst_i) |-> pin_sample_en_o == 12'hFFF
    && !conv_start_o && pair_irq_o == 4'h0) else $error("bad state after reset");
  chk_pin_pad: assert property (wb_ack_o && !wb_we_i && wb_adr_i[ADR_W-1:2] == 0
    |-> wb_dat_o[31:12] == 20'h00000) else $error("pin config upper bits set");
  chk_irq_cause: assert property (pair_irq_o != 4'h0 |-> $past(conv_done_i)
    && pair_irq_o == (4'h1 << conv_pair_o)) else $error("irq without completion");
  chk_no_overlap: assert property (conv_start_o |-> !busy_q)
    else $error("start while converting");
  chk_an_even: assert property (conv_an_even_o == {1'b0, conv_pair_o, 1'b0})
    else $error("input number does not match pair");
endmodule
bind aptc_ctrl aptc_ctrl_monitor #(.ADR_W(ADR_W)) i_mon (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .pin_dig_read_en_o,
  .pin_mux_gnd_o, .pin_sample_en_o, .conv_start_o, .conv_pair_o, .conv_an_even_o,
  .conv_done_i, .pair_irq_o);

// ==== tb/tb_top.sv ====
// self-checking bench for the pair trigger control block
// assumes design, core model and checker are compiled first
`timescale 1ns/1ps
module tb_top;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [3:0]  sel = 4'hF, lat = 4'h3;
  reg  [31:0] wdat = 32'h0, q;
  reg  [15:0] trig = 16'h0;
  reg  [5:0]  ord = 6'h0;
  reg  [3:0]  irq_seen = 4'h0;
  wire [31:0] rdat;
  wire        ack, start, done;
  wire [1:0]  pair;
  wire [3:0]  an_even, irq;
  wire [11:0] dig, gnd, smp;
  integer     mismatches = 0, n_compared = 0, n_start = 0, i;
  always #25 clk_i = ~clk_i;
  aptc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pin_dig_read_en_o(dig), .pin_mux_gnd_o(gnd), .pin_sample_en_o(smp),
    .glob_soft_trig_i(trig[0]), .pwm_spec_evt_i(trig[1]), .pwm_gen_trig_i(trig[5:2]),
    .tmr_period_i(trig[7:6]), .pwm_ilim_trig_i(trig[11:8]),
    .pwm_fault_trig_i(trig[15:12]), .conv_start_o(start), .conv_pair_o(pair),
    .conv_an_even_o(an_even), .conv_done_i(done), .pair_irq_o(irq));
  aptc_core_model i_core (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .lat_i(lat),
    .done_o(done));
  always @(posedge clk_i) begin
    if (start) begin
      n_start <= n_start + 1;
      ord <= {ord[3:0], pair};
    end
    irq_seen <= irq_seen | irq;
  end
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    integer k;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (k >= 20) begin mismatches++; close_out; end
  endtask
  task pulse(input [15:0] m);
    @(posedge clk_i); trig <= m;
    @(posedge clk_i); trig <= 16'h0;
  endtask
  task wait_starts(input integer n);
    integer k;
    k = 0;
    while (n_start < n && k < 300) begin @(posedge clk_i); k++; end
    if (k >= 300) begin mismatches++; close_out; end
  endtask
  task idle;
    repeat (24) @(posedge clk_i);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 3; i++) begin wb(0, 8'(i * 4), 0); chk("reset", q, 0); end
    wb(0, 8'h0C, 0); chk("unmapped", q, 0);
    $display("test reset ended");
    wb(1, 8'h00, 32'hFFFFFFFF); wb(0, 8'h00, 0); chk("pin cfg", q, 32'hFFF);
    wb(1, 8'h00, 32'h5A3); sel <= 4'h1; wb(1, 8'h00, 32'hFFF); sel <= 4'hF;
    chk("dig", {dig, gnd}, 24'h5FF5FF); chk("smp", smp, 32'hA00);
    $display("test pins ended");
    wb(1, 8'h04, 32'hA1); wait_starts(1);
    chk("pair0", {ord[1:0], an_even}, 0); idle;
    chk("irq", irq_seen, 4'h1); wb(0, 8'h04, 0); chk("ctl", q, 32'h81);
    $display("test soft ended");
    wb(1, 8'h04, 32'h22); wb(1, 8'h08, 32'h08); pulse(16'hFFFE); idle;
    chk("starts", n_start, 1); wb(0, 8'h04, 0); chk("soft", q, 32'h02);
    wb(1, 8'h04, 0);
    $display("test idle ended");
    for (i = 0; i < 16; i++) begin
      wb(1, 8'h08, {19'h0, 5'(i < 6 ? i + 2 : i < 12 ? i + 6 : i + 10), 8'h00});
      pulse(16'h1 << i); wait_starts(i + 2); idle;
      chk("pair3", {ord[1:0], an_even}, 32'h36);
    end
    $display("test codes ended");
    lat <= 4'h8; wb(1, 8'h04, 32'h300); wb(1, 8'h08, 32'h303); pulse(16'h2);
    wait_starts(20); idle; chk("order", ord, 6'b011011);
    chk("irq off", irq_seen, 4'h1);
    $display("test order ended");
    close_out;
  end
endmodule
